// ### pkg/dsm_pkg.sv
// Purpose: Shared constants and types for the deep stop mode controller
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   Offsets are byte addresses on the plain register port
package dsm_pkg;

    // Register offsets
    localparam logic [7:0] DSM_OFS_POWER_CTRL   = 8'h00; // power_mode_control_two
    localparam logic [7:0] DSM_OFS_EXT_INT      = 8'h01; // ext_int_status_control
    localparam logic [7:0] DSM_OFS_WAKE_SEL     = 8'h02;
    localparam logic [7:0] DSM_OFS_STOP_CMD     = 8'h03;
    localparam logic [7:0] DSM_OFS_STATUS       = 8'h04;

    // power_mode_control_two fields
    localparam int DSM_BIT_RECOVERY_FLAG = 3;
    localparam int DSM_BIT_LATCH_ACK     = 2;

    // ext_int_status_control fields
    localparam int DSM_BIT_EDGE_SEL   = 5;
    localparam int DSM_BIT_PIN_EN     = 4;
    localparam int DSM_BIT_INT_FLAG   = 3;
    localparam int DSM_BIT_INT_ACK    = 2;
    localparam int DSM_BIT_INT_EN     = 1;
    localparam int DSM_BIT_LEVEL_MODE = 0;

    // Stop command codes
    localparam logic [1:0] DSM_CMD_PARTIAL   = 2'h2;
    localparam logic [1:0] DSM_CMD_RETENTION = 2'h3;

    // Wake cause codes
    localparam logic [1:0] DSM_WAKE_NONE     = 2'h0;
    localparam logic [1:0] DSM_WAKE_EXT_INT  = 2'h1;
    localparam logic [1:0] DSM_WAKE_KEYPAD   = 2'h2;
    localparam logic [1:0] DSM_WAKE_PERIODIC = 2'h3;

    // Widths
    localparam int DSM_PIN_W    = 8;
    localparam int DSM_KEY_W    = 8;
    localparam int DSM_SEL_W    = 3;
    localparam int DSM_TICK_W   = 17;

    // Self-clocked source: 1 kHz tick from the 100 MHz clock
    localparam int DSM_CLK_HZ       = 100_000_000;
    localparam int DSM_SRC_HZ       = 1_000;
    localparam int DSM_SRC_DIV      = DSM_CLK_HZ / DSM_SRC_HZ;

    localparam logic [DSM_SEL_W-1:0] DSM_SEL_OFF = 3'h0;
    localparam logic [7:0]           DSM_ZERO8   = 8'h00;

    typedef enum logic [2:0] {
        DSM_RUN,
        DSM_PARTIAL_STOP,
        DSM_PARTIAL_WAKE,
        DSM_RETENTION_STOP,
        DSM_RETENTION_WAKE
    } dsm_state_t;

endpackage

// ### pkg/dsm_wake_if.sv
// Purpose: Carries the periodic wake timer link between controller and timer
// Assumes: Single clock domain
// Notes:   Controller owns the select, timer owns the wake pulse
`timescale 1ns/10ps
interface dsm_wake_if;
    import dsm_pkg::*;

    logic [DSM_SEL_W-1:0] wake_sel;
    logic                 wake_pulse;
    logic                 source_on;

    modport ctrl (
        output wake_sel,
        input  wake_pulse,
        input  source_on
    );

    modport timer (
        input  wake_sel,
        output wake_pulse,
        output source_on
    );
endinterface

// ### src/dsm_periodic_wake.sv
// Purpose: Periodic wake timer on a self-clocked 1 kHz tick
// Assumes: The tick is an enable pulse derived from the system clock
// Notes:   Select of zero stops both the source and the timer
`timescale 1ns/10ps
module dsm_periodic_wake
    import dsm_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  reset_i,
    // Controller link
    dsm_wake_if.timer  wake
);

    logic [DSM_TICK_W-1:0] src_cnt_q;
    logic                  src_tick;
    logic [9:0]            period_cnt_q;
    logic [9:0]            period_lim;

    // Period in 1 kHz ticks: 8, 32, 64, 128, 256, 512, 1024 ms
    always_comb begin
        case (wake.wake_sel)
            3'h1:    period_lim = 10'h007;
            3'h2:    period_lim = 10'h01f;
            3'h3:    period_lim = 10'h03f;
            3'h4:    period_lim = 10'h07f;
            3'h5:    period_lim = 10'h0ff;
            3'h6:    period_lim = 10'h1ff;
            default: period_lim = 10'h3ff;
        endcase
    end

    assign wake.source_on = (wake.wake_sel != DSM_SEL_OFF);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            src_cnt_q <= '0;
        end else if (!wake.source_on || src_cnt_q == DSM_TICK_W'(DSM_SRC_DIV - 1)) begin
            src_cnt_q <= '0;
        end else begin
            src_cnt_q <= src_cnt_q + 1'b1;
        end
    end

    assign src_tick = wake.source_on && (src_cnt_q == DSM_TICK_W'(DSM_SRC_DIV - 1));

    // Period counter, restarts whenever the source is off
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            period_cnt_q <= '0;
        end else if (!wake.source_on) begin
            period_cnt_q <= '0;
        end else if (src_tick) begin
            period_cnt_q <= (period_cnt_q >= period_lim) ? 10'h000 : period_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wake.wake_pulse <= 1'b0;
        end else begin
            wake.wake_pulse <= src_tick && (period_cnt_q >= period_lim);
        end
    end

endmodule

// ### src/dsm_controller.sv
// Purpose: Deep stop mode controller for partial power-down and retention stops
// Assumes: Pins are asynchronous to clk_sys_i; processor commands a stop by register
// Notes:   Stop clocks are modelled as gate outputs; the controller itself keeps
//          running so the synchronised wake paths stand in for the asynchronous ones.
`timescale 1ns/10ps
module dsm_controller
    import dsm_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_i,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [7:0]           reg_rdata_o,
    // Wake pins
    input  wire logic                 reset_pin_n_i,
    input  wire logic                 ext_int_pin_i,
    input  wire logic [DSM_KEY_W-1:0] keypad_interrupt_pins_i,
    input  wire logic [DSM_KEY_W-1:0] keypad_enable_i,
    // Pin drive path from port logic
    input  wire logic [DSM_PIN_W-1:0] port_out_i,
    input  wire logic [DSM_PIN_W-1:0] port_oe_i,
    input  wire logic [DSM_PIN_W-1:0] periph_out_i,
    input  wire logic [DSM_PIN_W-1:0] periph_oe_i,
    input  wire logic [DSM_PIN_W-1:0] periph_en_i,
    output logic      [DSM_PIN_W-1:0] pin_out_o,
    output logic      [DSM_PIN_W-1:0] pin_oe_o,
    // Ext pin pull control
    output logic                      ext_pull_up_o,
    output logic                      ext_pull_down_o,
    // System power and clock control
    output logic                      sys_clk_en_o,
    output logic                      osc_en_o,
    output logic                      clock_generator_en_o,
    output logic                      analog_converter_en_o,
    output logic                      regulator_standby_o,
    output logic                      core_power_on_o,
    output logic                      periph_reset_o,
    output logic                      retention_hold_o,
    // Vector request to the processor
    output logic                      reset_vector_o,
    output logic                      int_vector_o,
    output logic [1:0]                wake_cause_o,
    output logic                      ext_int_req_o
);

    dsm_wake_if wake ();

    dsm_state_t state_q;

    logic       rst_pin_m_q, rst_pin_q;
    logic       ext_m_q, ext_q, ext_prev_q;
    logic [DSM_KEY_W-1:0] key_m_q, key_q;

    logic       recovery_flag_q;
    logic       latch_closed_q;
    logic [DSM_PIN_W-1:0] latch_out_q, latch_oe_q;
    logic       pin_en_q, edge_sel_q, level_mode_q, int_en_q, ext_flag_q;
    logic [DSM_SEL_W-1:0] wake_sel_q;
    logic [1:0] cause_q;
    logic       reset_vec_q, int_vec_q;

    logic       wr_power, wr_ext, wr_sel, wr_cmd;
    logic       ack_write;
    logic       ext_active, ext_edge, ext_event;
    logic       stop_ext_wake, key_wake, stopped;

    // Register write decode
    assign wr_power = reg_wr_i && (reg_addr_i == DSM_OFS_POWER_CTRL);
    assign wr_ext   = reg_wr_i && (reg_addr_i == DSM_OFS_EXT_INT);
    assign wr_sel   = reg_wr_i && (reg_addr_i == DSM_OFS_WAKE_SEL);
    assign wr_cmd   = reg_wr_i && (reg_addr_i == DSM_OFS_STOP_CMD);
    assign ack_write = wr_power && reg_wdata_i[DSM_BIT_LATCH_ACK];

    // Pin synchronisers; first stage read only by the second
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rst_pin_m_q <= 1'b1;
            rst_pin_q   <= 1'b1;
            ext_m_q     <= 1'b1;
            ext_q       <= 1'b1;
            key_m_q     <= '1;
            key_q       <= '1;
        end else begin
            rst_pin_m_q <= reset_pin_n_i;
            rst_pin_q   <= rst_pin_m_q;
            ext_m_q     <= ext_int_pin_i;
            ext_q       <= ext_m_q;
            key_m_q     <= keypad_interrupt_pins_i;
            key_q       <= key_m_q;
        end
    end

    // Previous ext pin level for edge detection
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_q;
        end
    end

    // polarity from edge select, edge or level
    assign ext_active = edge_sel_q ? ext_q : !ext_q;
    assign ext_edge   = edge_sel_q ? (ext_q && !ext_prev_q) : (!ext_q && ext_prev_q);
    assign ext_event  = pin_en_q && (ext_edge || (level_mode_q && ext_active));

    // active low in partial stop regardless of edge select; pin enable still required
    assign stop_ext_wake = pin_en_q && ((state_q == DSM_PARTIAL_STOP) ? !ext_q : ext_active);
    assign key_wake      = |(~key_q & keypad_enable_i);
    assign stopped       = (state_q == DSM_PARTIAL_STOP) || (state_q == DSM_RETENTION_STOP);

    // Ext interrupt control and flag
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_en_q     <= 1'b0;
            edge_sel_q   <= 1'b0;
            level_mode_q <= 1'b0;
            int_en_q     <= 1'b0;
        end else if (state_q == DSM_PARTIAL_WAKE || (state_q == DSM_RETENTION_WAKE && reset_vec_q)) begin
            pin_en_q     <= 1'b0;
            edge_sel_q   <= 1'b0;
            level_mode_q <= 1'b0;
            int_en_q     <= 1'b0;
        end else if (wr_ext) begin
            pin_en_q     <= reg_wdata_i[DSM_BIT_PIN_EN];
            edge_sel_q   <= reg_wdata_i[DSM_BIT_EDGE_SEL];
            level_mode_q <= reg_wdata_i[DSM_BIT_LEVEL_MODE];
            int_en_q     <= reg_wdata_i[DSM_BIT_INT_EN];
        end
    end

    // Flag: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_flag_q <= 1'b0;
        end else if (ext_event && !stopped) begin
            ext_flag_q <= 1'b1;
        end else if (state_q == DSM_PARTIAL_WAKE) begin
            ext_flag_q <= 1'b0;
        end else if (wr_ext && reg_wdata_i[DSM_BIT_INT_ACK]) begin
            ext_flag_q <= 1'b0;
        end
    end

    // interrupt raised only when enabled, else flag only
    assign ext_int_req_o = ext_flag_q && int_en_q;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wake_sel_q <= DSM_SEL_OFF;
        end else if (wr_sel) begin
            wake_sel_q <= reg_wdata_i[DSM_SEL_W-1:0];
        end
    end

    assign wake.wake_sel = wake_sel_q;

    dsm_periodic_wake u_periodic (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .wake      (wake.timer)
    );

    // Stop sequencing
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= DSM_RUN;
        end else begin
            case (state_q)
                DSM_RUN: begin
                    if (wr_cmd && reg_wdata_i[1:0] == DSM_CMD_PARTIAL) begin
                        state_q <= DSM_PARTIAL_STOP;
                    end else if (wr_cmd && reg_wdata_i[1:0] == DSM_CMD_RETENTION) begin
                        state_q <= DSM_RETENTION_STOP;
                    end
                end
                DSM_PARTIAL_STOP: begin
                    // only reset pin, ext pin, periodic
                    if (!rst_pin_q || stop_ext_wake || wake.wake_pulse) begin
                        state_q <= DSM_PARTIAL_WAKE;
                    end
                end
                DSM_PARTIAL_WAKE: begin
                    state_q <= DSM_RUN;
                end
                DSM_RETENTION_STOP: begin
                    if (!rst_pin_q || stop_ext_wake || key_wake || wake.wake_pulse) begin
                        state_q <= DSM_RETENTION_WAKE;
                    end
                end
                DSM_RETENTION_WAKE: begin
                    state_q <= DSM_RUN;
                end
                default: state_q <= DSM_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reset_vec_q <= 1'b0;
            int_vec_q   <= 1'b0;
            cause_q     <= DSM_WAKE_NONE;
        end else begin
            reset_vec_q <= 1'b0;
            int_vec_q   <= 1'b0;
            if (state_q == DSM_PARTIAL_STOP && (!rst_pin_q || stop_ext_wake || wake.wake_pulse)) begin
                // partial wake always takes the reset vector
                reset_vec_q <= 1'b1;
                cause_q     <= !rst_pin_q ? DSM_WAKE_NONE :
                               stop_ext_wake ? DSM_WAKE_EXT_INT : DSM_WAKE_PERIODIC;
            end else if (state_q == DSM_RETENTION_STOP) begin
                if (!rst_pin_q) begin
                    reset_vec_q <= 1'b1;
                    cause_q     <= DSM_WAKE_NONE;
                end else if (stop_ext_wake) begin
                    int_vec_q <= 1'b1;
                    cause_q   <= DSM_WAKE_EXT_INT;
                end else if (key_wake) begin
                    int_vec_q <= 1'b1;
                    cause_q   <= DSM_WAKE_KEYPAD;
                end else if (wake.wake_pulse) begin
                    int_vec_q <= 1'b1;
                    cause_q   <= DSM_WAKE_PERIODIC;
                end
            end
        end
    end

    // recovery flag set on partial wake, cleared by acknowledge
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            recovery_flag_q <= 1'b0;
        end else if (state_q == DSM_PARTIAL_WAKE) begin
            recovery_flag_q <= 1'b1;
        end else if (ack_write) begin
            // flag cleared by the same write
            recovery_flag_q <= 1'b0;
        end
    end

    // latch pin state on partial stop entry
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            latch_closed_q <= 1'b0;
            latch_out_q    <= '0;
            latch_oe_q     <= '0;
        end else if (state_q == DSM_RUN && wr_cmd && reg_wdata_i[1:0] == DSM_CMD_PARTIAL) begin
            latch_closed_q <= 1'b1;
            latch_out_q    <= pin_out_o;
            latch_oe_q     <= pin_oe_o;
        end else if (ack_write && state_q == DSM_RUN) begin
            // latches open with the flag clear
            latch_closed_q <= 1'b0;
        end
    end

    // disabled peripheral hands pin to port control
    // unrestored port registers show reset states
    // retention pins held by the retained drive logic
    always_comb begin
        if (latch_closed_q) begin
            pin_out_o = latch_out_q;
            pin_oe_o  = latch_oe_q;
        end else begin
            pin_out_o = (periph_en_i & periph_out_i) | (~periph_en_i & port_out_i);
            pin_oe_o  = (periph_en_i & periph_oe_i) | (~periph_en_i & port_oe_i);
        end
    end

    assign ext_pull_down_o = pin_en_q && edge_sel_q;
    assign ext_pull_up_o   = pin_en_q && !edge_sel_q;

    // retention halts clocks, converter, regulator standby
    assign sys_clk_en_o          = !stopped;
    assign osc_en_o              = !stopped;
    assign clock_generator_en_o  = !stopped;
    assign analog_converter_en_o = !stopped;
    assign regulator_standby_o   = stopped;
    // core off in partial stop, peripherals reset on its wake
    assign core_power_on_o       = (state_q != DSM_PARTIAL_STOP);
    assign periph_reset_o        = (state_q == DSM_PARTIAL_STOP) || (state_q == DSM_PARTIAL_WAKE);
    // retention keeps register and memory content
    assign retention_hold_o      = (state_q == DSM_RETENTION_STOP);
    assign reset_vector_o        = reset_vec_q;
    assign int_vector_o          = int_vec_q;
    assign wake_cause_o          = cause_q;

    // Register read, data one cycle later; unmapped reads zero
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= DSM_ZERO8;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                DSM_OFS_POWER_CTRL: reg_rdata_o <= {4'h0, recovery_flag_q, 3'h0};
                DSM_OFS_EXT_INT:    reg_rdata_o <= {2'h0, edge_sel_q, pin_en_q, ext_flag_q, 1'b0,
                                                    int_en_q, level_mode_q};
                DSM_OFS_WAKE_SEL:   reg_rdata_o <= {5'h00, wake_sel_q};
                DSM_OFS_STATUS:     reg_rdata_o <= {1'b0, wake.source_on, latch_closed_q, state_q, cause_q};
                default:            reg_rdata_o <= DSM_ZERO8;
            endcase
        end else begin
            reg_rdata_o <= DSM_ZERO8;
        end
    end

endmodule

// ### sim/dsm_controller_checker.sv
// Purpose: Port assertions for the deep stop mode controller
// Assumes: One clock; reset_i asynchronous, active high
// Notes:   Sees top-level ports only and is bound below
`timescale 1ns/10ps
module dsm_controller_checker
    import dsm_pkg::*;
(
    // Clock and reset
    input wire logic                 clk_sys_i,
    input wire logic                 reset_i,
    // Pins and pulls
    input wire logic [DSM_PIN_W-1:0] pin_out_o,
    input wire logic                 ext_pull_up_o,
    input wire logic                 ext_pull_down_o,
    // Power and clock gates
    input wire logic                 sys_clk_en_o,
    input wire logic                 osc_en_o,
    input wire logic                 clock_generator_en_o,
    input wire logic                 analog_converter_en_o,
    input wire logic                 regulator_standby_o,
    input wire logic                 core_power_on_o,
    input wire logic                 periph_reset_o,
    input wire logic                 retention_hold_o,
    // Vector requests
    input wire logic                 reset_vector_o,
    input wire logic                 int_vector_o
);
    default clocking dsm_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Stop exits, seen as core power returning or the retention hold dropping
    sequence seq_partial_exit;
        !core_power_on_o ##1 core_power_on_o;
    endsequence
    sequence seq_retention_exit;
        retention_hold_o ##1 !retention_hold_o;
    endsequence

    AST_STOP_CLOCKS: assert property (
        {sys_clk_en_o, osc_en_o, clock_generator_en_o, analog_converter_en_o} == {4{!regulator_standby_o}})
        else $error("clock gates disagree with regulator standby");
    AST_RET_KEEPS: assert property (retention_hold_o |-> regulator_standby_o && core_power_on_o)
        else $error("retention stop lost core power");
    AST_LATCH_HOLD: assert property (!core_power_on_o ##1 !core_power_on_o |-> $stable(pin_out_o))
        else $error("pin drive moved during partial stop");
    AST_PART_RESET: assert property (!core_power_on_o |-> periph_reset_o && !retention_hold_o)
        else $error("peripherals not held in reset in partial stop");
    AST_PART_EXIT: assert property (seq_partial_exit |-> ##[0:2] reset_vector_o)
        else $error("partial stop exit without reset vector");
    AST_PART_NO_INT: assert property (seq_partial_exit |-> !int_vector_o [*3])
        else $error("interrupt vector after partial stop");
    AST_RET_EXIT: assert property (seq_retention_exit |-> ##[0:2] (reset_vector_o || int_vector_o))
        else $error("retention exit without a vector");
    AST_VEC_PULSE: assert property ((reset_vector_o || int_vector_o) |=> !(reset_vector_o || int_vector_o))
        else $error("vector request longer than one cycle");
    AST_PULLS: assert property (!(ext_pull_up_o && ext_pull_down_o))
        else $error("pullup and pulldown both on");
endmodule
bind dsm_controller dsm_controller_checker i_dsm_controller_checker (.*);

// ### sim/dsm_pin_model.sv
// Purpose: Far side of the controller: wake pins and port setup by software
// Assumes: Pins idle high through pull-ups
// Notes:   A press holds one source low for a set number of cycles
`timescale 1ns/10ps
module dsm_pin_model
    import dsm_pkg::*;
(
    // Clock
    input  wire logic                 clk_sys_i,
    // Wake pins
    output logic                      reset_pin_n_o,
    output logic                      ext_int_pin_o,
    output logic [DSM_KEY_W-1:0]      keypad_pins_o,
    // Port and peripheral drive
    output logic [DSM_PIN_W-1:0]      port_out_o,
    output logic [DSM_PIN_W-1:0]      port_oe_o,
    output logic [DSM_PIN_W-1:0]      periph_out_o,
    output logic [DSM_PIN_W-1:0]      periph_oe_o,
    output logic [DSM_PIN_W-1:0]      periph_en_o
);
    int src_q = 0;
    int hold_q = 0;

    // Idle levels at time zero
    initial begin
        {reset_pin_n_o, ext_int_pin_o, keypad_pins_o} = '1;
        {port_out_o, periph_out_o, periph_en_o} = '0;
        {port_oe_o, periph_oe_o} = '1;
    end

    // Source 0 reset pin, 1 external pin, 2 keypad pin 0
    task automatic press(input int src, input int cycles);
        src_q  <= src;
        hold_q <= cycles;
    endtask

    task automatic setup(input logic [7:0] po, input logic [7:0] pe, input logic [7:0] eo);
        port_out_o   <= po;
        periph_en_o  <= pe;
        periph_out_o <= eo;
    endtask

    // Released pins go back to the pull-up level
    always @(posedge clk_sys_i) begin
        reset_pin_n_o <= !(hold_q > 0 && src_q == 0);
        ext_int_pin_o <= !(hold_q > 0 && src_q == 1);
        keypad_pins_o <= (hold_q > 0 && src_q == 2) ? 8'hfe : 8'hff;
        if (hold_q > 0) hold_q <= hold_q - 1;
    end
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the deep stop mode controller
// Assumes: Pin model drives wake pins and port setup
// Notes:   Periodic wake checked through its source flag only; a real tick is too slow
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top
    import dsm_pkg::*;
;
    logic       clk_sys_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] keypad_enable = 8'h00;
    logic [7:0] reg_rdata, pin_out, port_out, port_oe, periph_out, periph_oe, periph_en, keypad_pins, pin_oe;
    logic       reset_pin_n, ext_pin, pull_up, pull_down, sys_clk_en, osc_en, cg_en, adc_en;
    logic       standby, ret_hold, reset_vector, int_vector, ext_int_req;
    int         failures = 0;
    int         checked = 0;
    int         cycles = 0;
    int         src;

    always #5 clk_sys_i = !clk_sys_i;

    dsm_pin_model i_dsm_pin_model (.clk_sys_i(clk_sys_i), .reset_pin_n_o(reset_pin_n),
        .ext_int_pin_o(ext_pin), .keypad_pins_o(keypad_pins), .port_out_o(port_out), .port_oe_o(port_oe),
        .periph_out_o(periph_out), .periph_oe_o(periph_oe), .periph_en_o(periph_en));

    dsm_controller i_dsm_controller (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .reset_pin_n_i(reset_pin_n), .ext_int_pin_i(ext_pin), .keypad_interrupt_pins_i(keypad_pins),
        .keypad_enable_i(keypad_enable), .port_out_i(port_out), .port_oe_i(port_oe),
        .periph_out_i(periph_out), .periph_oe_i(periph_oe), .periph_en_i(periph_en), .pin_out_o(pin_out),
        .pin_oe_o(pin_oe), .ext_pull_up_o(pull_up), .ext_pull_down_o(pull_down), .sys_clk_en_o(sys_clk_en),
        .osc_en_o(osc_en), .clock_generator_en_o(cg_en), .analog_converter_en_o(adc_en),
        .regulator_standby_o(standby), .core_power_on_o(), .periph_reset_o(), .retention_hold_o(ret_hold),
        .reset_vector_o(reset_vector), .int_vector_o(int_vector), .wake_cause_o(), .ext_int_req_o(ext_int_req));

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys_i);
        `CHK("register", e, d)
    endtask

    // Long enough for pin sync and a released press to clear
    task automatic settle();
        repeat (12) @(posedge clk_sys_i);
        #1;
    endtask

    // Bounded wait for the one-cycle vector pulse
    task automatic wait_vec(input logic want_reset);
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_sys_i);
            #1;
            if (reset_vector === 1'b1 || int_vector === 1'b1) break;
        end
        `CHK("reset vector", want_reset, reset_vector)
        `CHK("interrupt vector", !want_reset, int_vector)
        @(posedge clk_sys_i);
    endtask

    task automatic complete_run();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard; the run needs well under 2000 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        check_reg(DSM_OFS_STATUS, 8'h00);
        check_reg(8'h1f, 8'h00);
        reg_write(DSM_OFS_WAKE_SEL, 8'h01);
        check_reg(DSM_OFS_STATUS, 8'h40);
        reg_write(DSM_OFS_WAKE_SEL, 8'h00);
        check_reg(DSM_OFS_STATUS, 8'h00);
        reg_write(DSM_OFS_EXT_INT, 8'h30);
        #1 `CHK("pulls", 2'b01, {pull_up, pull_down})
        // External pin in run: flag, request, clear, then disabled pin
        reg_write(DSM_OFS_EXT_INT, 8'h12);
        i_dsm_pin_model.press(1, 4);
        settle();
        `CHK("ext request", 1'b1, ext_int_req)
        check_reg(DSM_OFS_EXT_INT, 8'h1a);
        reg_write(DSM_OFS_EXT_INT, 8'h16);
        #1 `CHK("ext cleared", 1'b0, ext_int_req)
        reg_write(DSM_OFS_EXT_INT, 8'h02);
        i_dsm_pin_model.press(1, 4);
        settle();
        `CHK("ext disabled", 1'b0, ext_int_req)
        // Partial stop: keypad ignored, low pin wakes despite rising edge setup
        i_dsm_pin_model.setup(8'ha5, 8'h00, 8'h00);
        reg_write(DSM_OFS_EXT_INT, 8'h30);
        reg_write(DSM_OFS_STOP_CMD, {6'h00, DSM_CMD_PARTIAL});
        i_dsm_pin_model.setup(8'h00, 8'h00, 8'h00);
        keypad_enable <= 8'h01;
        i_dsm_pin_model.press(2, 4);
        settle();
        `CHK("latched pins", 8'ha5, pin_out)
        `CHK("latched enables", 8'hff, pin_oe)
        check_reg(DSM_OFS_STATUS, 8'h24);
        i_dsm_pin_model.press(1, 4);
        wait_vec(1'b1);
        #1 `CHK("held pins", 8'ha5, pin_out)
        check_reg(DSM_OFS_POWER_CTRL, 8'h08);
        check_reg(DSM_OFS_EXT_INT, 8'h00);
        check_reg(DSM_OFS_STATUS, 8'h21);
        i_dsm_pin_model.setup(8'h3c, 8'h0f, 8'hff);
        reg_write(DSM_OFS_POWER_CTRL, 8'h04);
        #1 `CHK("released pins", 8'h3f, pin_out)
        check_reg(DSM_OFS_POWER_CTRL, 8'h00);
        // Retention stop left by keypad, external pin, then reset pin
        reg_write(DSM_OFS_EXT_INT, 8'h10);
        for (src = 2; src >= 0; src--) begin
            settle();
            reg_write(DSM_OFS_STOP_CMD, {6'h00, DSM_CMD_RETENTION});
            #1 `CHK("gates", 6'b000011, {sys_clk_en, osc_en, cg_en, adc_en, standby, ret_hold})
            i_dsm_pin_model.press(src, 4);
            wait_vec(src == 0);
            check_reg(DSM_OFS_STATUS, 8'(src));
        end
        check_reg(DSM_OFS_EXT_INT, 8'h00);
        complete_run();
    end
endmodule
